// ===== bench/conv_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// converter stand-in with a fixed conversion time
// ------------------------------------------------------------
module conv_model #(
  parameter int CONV_CYC = 360
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic [15:0] temp_in,
  output logic conv_done,
  output logic [15:0] conv_value
);
  int left;
  logic [15:0] last;

  // a new start restarts the count, so a run cut off by a new start never reports
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      left <= 0;
      conv_done <= 1'b0;
      last <= 16'h0000;
    end
    else
    begin
      conv_done <= 1'b0;
      if (conv_start)
        left <= CONV_CYC;
      else if (left == 1)
      begin
        conv_done <= 1'b1;
        last <= temp_in;
        left <= 0;
      end
      else if (left > 1)
        left <= left - 1;
    end

  // value scrambled outside the done cycle so a late sample cannot pass
  assign conv_value = conv_done ? last : ~last;
endmodule : conv_model

// ===== bench/temp_alert_monitor.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// converter handshake, read port and alert pin checks
// ------------------------------------------------------------
module temp_alert_monitor (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic txn_start,
  input wire logic ptr_wr,
  input wire logic [temp_alert_pkg::BYTE_W-1:0] ptr_data,
  input wire logic data_wr,
  input wire logic [temp_alert_pkg::BYTE_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic [temp_alert_pkg::BYTE_W-1:0] rd_data,
  input wire logic conv_start,
  input wire logic meas_power,
  input wire logic conv_done,
  input wire logic [temp_alert_pkg::REG_W-1:0] conv_value,
  input wire logic alert_pin
);
  import temp_alert_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic [1:0] cyc;
  logic [2:0] since;

  // cycles since reset release, saturating so it costs two flops only
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      cyc <= 2'h0;
    else if (cyc != 2'h3)
      cyc <= cyc + 2'h1;

  // cycles since the last event that may move the alert pin
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      since <= 3'h0;
    else if (conv_done || rd_req || data_wr)
      since <= 3'h0;
    else if (since != 3'h7)
      since <= since + 3'h1;

  sequence s_conv_open;
    conv_start && meas_power;
  endsequence

  a_start_powered: assert property (conv_start |-> s_conv_open)
    else $error("start without power");
  a_power_rise: assert property ($rose(meas_power) |-> conv_start)
    else $error("power without start");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_idle: assert property (conv_start |-> !$past(meas_power))
    else $error("start during a conversion");
  a_power_on_conv: assert property (cyc == 2'h1 |-> ##[0:2] conv_start)
    else $error("no conversion after reset");
  sequence s_result_in;
    meas_power && conv_done;
  endsequence

  a_done_ends: assert property (s_result_in |=>
    !meas_power && !conv_start)
    else $error("conversion did not end on its result");
  a_done_drops: assert property (meas_power && conv_done |=> !meas_power)
    else $error("power stays after result");
  a_conv_holds: assert property (meas_power && !conv_done && !data_wr
    && !$past(data_wr) |=> meas_power)
    else $error("conversion dropped without cause");
  a_read_answer: assert property ($changed(rd_data) |-> $past(rd_req))
    else $error("read byte moved without request");
  a_alert_cause: assert property ($changed(alert_pin) |-> since <= 3'h3)
    else $error("alert moved without result or access");
endmodule : temp_alert_monitor

bind temp_alert_ctrl temp_alert_monitor mon (.sys_clk, .reset_n, .txn_start,
  .ptr_wr, .ptr_data, .data_wr, .wr_data, .rd_req, .rd_data, .conv_start,
  .meas_power, .conv_done, .conv_value, .alert_pin);

// ===== bench/testbench.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// register port bench
// ------------------------------------------------------------
module testbench;
  import temp_alert_pkg::*;
  localparam int CPM = 10;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic txn_start = 1'b0;
  logic ptr_wr = 1'b0;
  logic [7:0] ptr_data = 8'h00;
  logic data_wr = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rd_req = 1'b0;
  logic [7:0] rd_data;
  logic conv_start, meas_power, conv_done, alert_pin;
  logic [15:0] conv_value;
  logic [15:0] temp_in = 16'h1000;
  logic [15:0] v;
  int per [4] = '{PERIOD_MS_0 * CPM, PERIOD_MS_1 * CPM, PERIOD_MS_2 * CPM,
    PERIOD_MS_3 * CPM};
  logic [15:0] seq_t [8] = '{16'h2800, 16'h1000, 16'h2800, 16'h2800,
    16'he000, 16'h0000, 16'he000, 16'hec00};
  logic seq_p [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  int miscompares = 0;
  int total_checks = 0;
  int n;
  bit ok;

  always #5 sys_clk = ~sys_clk;

  temp_alert_ctrl #(.CYCLES_PER_MS(CPM)) DUT (.sys_clk, .reset_n, .txn_start,
    .ptr_wr, .ptr_data, .data_wr, .wr_data, .rd_req, .rd_data, .conv_start,
    .meas_power, .conv_done, .conv_value, .alert_pin);
  conv_model #(.CONV_CYC(360)) conv (.sys_clk, .reset_n, .conv_start,
    .temp_in, .conv_done, .conv_value);

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // start then index pointer; a start first keeps the byte phase clean
  task automatic point(input logic [1:0] idx);
    @(negedge sys_clk);
    txn_start = 1'b1;
    @(negedge sys_clk);
    txn_start = 1'b0;
    ptr_wr = 1'b1;
    ptr_data = {6'h00, idx};
    @(negedge sys_clk);
    ptr_wr = 1'b0;
  endtask : point

  task automatic wr_reg(input logic [1:0] idx, input logic [15:0] val);
    point(idx);
    data_wr = 1'b1;
    wr_data = val[15:8];
    @(negedge sys_clk);
    wr_data = val[7:0];
    @(negedge sys_clk);
    data_wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [1:0] idx, input logic [15:0] exp);
    logic [15:0] val;
    point(idx);
    rd_req = 1'b1;
    @(negedge sys_clk);
    val[15:8] = rd_data;
    @(negedge sys_clk);
    val[7:0] = rd_data;
    rd_req = 1'b0;
    check(val, exp);
  endtask : rd_chk

  task automatic wait_done(input int lim, output bit got, output int cnt);
    got = 1'b0;
    cnt = 0;
    while (!got && cnt < lim)
    begin
      @(negedge sys_clk);
      cnt++;
      got = (conv_done === 1'b1);
    end
  endtask : wait_done

  task automatic need(input int lim);
    wait_done(lim, ok, n);
    if (!ok)
    begin
      miscompares++;
      $display("BAD %0t no conversion result", $time);
      test_done();
    end
  endtask : need

  task automatic pin_chk(input logic e);
    repeat (3) @(negedge sys_clk);
    check({15'h0000, alert_pin}, {15'h0000, e});
  endtask : pin_chk

  task automatic conv_to(input logic [15:0] t, input logic e);
    temp_in = t;
    need(1400);
    pin_chk(e);
  endtask : conv_to

  // main sequence
  initial
  begin
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    rd_chk(IDX_CONFIG, 16'h40a0);
    rd_chk(IDX_LOWER, 16'h2580);
    rd_chk(IDX_UPPER, 16'h2800);
    rd_chk(IDX_RESULT, 16'h0000);
    need(510);
    rd_chk(IDX_RESULT, 16'h1000);
    $display("test power_up done");
    for (int i = 0; i < 4; i++)
    begin
      v = 16'h201f | (16'(i) << 11) | (16'(i) << 6);
      wr_reg(IDX_CONFIG, v);
      rd_chk(IDX_CONFIG, (v & 16'h18c0) | 16'h4020);
    end
    for (int i = 1; i < 4; i++)
    begin
      wr_reg(IDX_CONFIG, 16'(i) << 6);
      need(2 * per[i] + 400);
      need(2 * per[i] + 400);
      need(2 * per[i] + 400);
      check(16'(n), 16'(per[i]));
    end
    $display("test config_rate done");
    wr_reg(IDX_UPPER, 16'h280f);
    rd_chk(IDX_UPPER, 16'h2800);
    wr_reg(IDX_LOWER, 16'hec00);
    wr_reg(IDX_RESULT, 16'h1234);
    rd_chk(IDX_RESULT, 16'h1000);
    wr_reg(IDX_CONFIG, 16'h08c0);
    for (int i = 0; i < 8; i++)
    begin
      conv_to(seq_t[i], seq_p[i]);
      if (i == 3)
        rd_chk(IDX_CONFIG, 16'h48c0);
    end
    wr_reg(IDX_CONFIG, 16'h0cc0);
    pin_chk(1'b0);
    rd_chk(IDX_CONFIG, 16'h4cc0);
    $display("test comparator done");
    // second reset in mid-run, then interrupt behaviour
    reset_n = 1'b0;
    temp_in = 16'h2800;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    wr_reg(IDX_CONFIG, 16'h02c0);
    conv_to(16'h2800, 1'b0);
    rd_chk(IDX_RESULT, 16'h2800);
    pin_chk(1'b1);
    conv_to(16'h2800, 1'b1);
    conv_to(16'h2580, 1'b0);
    $display("test interrupt done");
    wr_reg(IDX_CONFIG, 16'h83c0);
    pin_chk(1'b1);
    rd_chk(IDX_CONFIG, 16'hc3e0);
    temp_in = 16'h0c80;
    need(510);
    rd_chk(IDX_CONFIG, 16'h43e0);
    rd_chk(IDX_RESULT, 16'h0c80);
    wait_done(3000, ok, n);
    check({15'h0000, ok}, 16'h0000);
    wr_reg(IDX_UPPER, 16'h3000);
    rd_chk(IDX_UPPER, 16'h3000);
    wr_reg(IDX_CONFIG, 16'h80c0);
    rd_chk(IDX_CONFIG, 16'h40e0);
    need(400);
    need(1400);
    check(16'(n), 16'(per[3]));
    $display("test sleep done");
    // four faults needed: three hits leave the pin idle, the fourth fires
    wr_reg(IDX_CONFIG, 16'h18c0);
    for (int i = 0; i < 4; i++)
      conv_to(16'h3000, i < 3);
    $display("test fault_count done");
    test_done();
  end
endmodule : testbench

// ===== hw/temp_alert_ctrl.sv
`timescale 1ns/1ns

module temp_alert_ctrl #(
  parameter int CYCLES_PER_MS = temp_alert_pkg::CYCLES_PER_MS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // byte port from the two-wire protocol engine
  input wire logic txn_start,
  input wire logic ptr_wr,
  input wire logic [temp_alert_pkg::BYTE_W-1:0] ptr_data,
  input wire logic data_wr,
  input wire logic [temp_alert_pkg::BYTE_W-1:0] wr_data,
  input wire logic rd_req,
  output logic [temp_alert_pkg::BYTE_W-1:0] rd_data,
  // converter
  output logic conv_start,
  output logic meas_power,
  input wire logic conv_done,
  input wire logic [temp_alert_pkg::REG_W-1:0] conv_value,
  // alert pin
  output logic alert_pin
);
  import temp_alert_pkg::*;

  // ------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------
  logic [1:0] index_ptr;
  logic byte_phase;
  logic [BYTE_W-1:0] msb_hold;
  logic [REG_W-1:0] read_snap;
  logic [REG_W-1:0] temperature_result;
  logic [REG_W-1:0] lower_limit;
  logic [REG_W-1:0] upper_limit;
  logic [1:0] sample_rate_select;
  logic low_power_select;
  logic latch_mode_select;
  logic active_level_select;
  logic [1:0] fault_count_select;
  logic one_shot_busy;
  logic cmp_active;
  logic int_active;
  logic int_expect_low;
  logic [2:0] cmp_count;
  logic [2:0] int_count;
  logic [TIMER_W-1:0] rate_timer;
  logic power_on_pending;
  conv_state_e conv_state;

  logic [REG_W-1:0] word_in;
  logic commit;
  logic cfg_commit;
  logic sleep_enter;
  logic sleep_leave;
  logic one_shot_req;
  logic result_valid;
  logic over_upper;
  logic under_lower;
  logic [2:0] fault_target;
  logic limit_flag;
  logic [REG_W-1:0] cfg_read;
  logic [REG_W-1:0] sel_word;
  logic [TIMER_W-1:0] period_cycles;
  logic timer_due;

  // ------------------------------------------------------------
  // byte assembly and decode
  // ------------------------------------------------------------
  // the second data byte commits the whole word, first byte is the msb
  assign word_in = {msb_hold, wr_data};
  assign commit = data_wr && byte_phase;
  assign cfg_commit = commit && (index_ptr == IDX_CONFIG);
  assign sleep_enter = cfg_commit && word_in[CFG_LOW_POWER]
                       && !low_power_select;
  assign sleep_leave = cfg_commit && !word_in[CFG_LOW_POWER]
                       && low_power_select;
  // one-shot only counts when the same word leaves sleep set
  assign one_shot_req = cfg_commit && word_in[CFG_ONE_SHOT]
                        && word_in[CFG_LOW_POWER]
                        && (conv_state == st_standby);
  assign result_valid = conv_done && (conv_state == st_convert);

  // signed compares; a hit on the limit counts as crossing it
  assign over_upper = $signed(conv_value) >= $signed(upper_limit);
  assign under_lower = $signed(conv_value) <= $signed(lower_limit);
  assign fault_target = {1'b0, fault_count_select} + 3'd1;

  // flag level follows the comparator state through the polarity
  assign limit_flag = active_level_select ? cmp_active
                                          : !cmp_active;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb
  begin
    cfg_read = '0;
    cfg_read[CFG_LIMIT_FLAG] = limit_flag;
    cfg_read[CFG_RATE_HI:CFG_RATE_LO] = sample_rate_select;
    cfg_read[CFG_LOW_POWER] = low_power_select;
    cfg_read[CFG_LATCH_MODE] = latch_mode_select;
    cfg_read[CFG_ACTIVE_LEVEL] = active_level_select;
    cfg_read[CFG_FAULT_HI:CFG_FAULT_LO] = fault_count_select;
    cfg_read[CFG_ONE_READS_ONE] = 1'b1;
    cfg_read[CFG_ONE_SHOT] = one_shot_busy;
  end

  // registers stay reachable in every power state
  always_comb
  begin
    unique case (index_ptr)
      IDX_RESULT: sel_word = temperature_result;
      IDX_CONFIG: sel_word = cfg_read;
      IDX_LOWER: sel_word = lower_limit;
      IDX_UPPER: sel_word = upper_limit;
    endcase
  end

  // ------------------------------------------------------------
  // pointer and byte sequencing
  // ------------------------------------------------------------
  // a new transaction or pointer write always restarts at the msb
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      index_ptr <= IDX_RESULT;
      byte_phase <= 1'b0;
      msb_hold <= '0;
    end
    else if (txn_start)
    begin
      byte_phase <= 1'b0;
    end
    else if (ptr_wr)
    begin
      index_ptr <= ptr_data[1:0];
      byte_phase <= 1'b0;
    end
    else if (data_wr || rd_req)
    begin
      byte_phase <= !byte_phase;
      if (data_wr && !byte_phase)
      begin
        msb_hold <= wr_data;
      end
    end
  end

  // word is frozen at the msb so both bytes belong to one value
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      read_snap <= '0;
      rd_data <= '0;
    end
    else if (rd_req && !txn_start && !ptr_wr)
    begin
      if (!byte_phase)
      begin
        read_snap <= sel_word;
        rd_data <= sel_word[REG_W-1:BYTE_W];
      end
      else
      begin
        rd_data <= read_snap[BYTE_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // writable registers
  // ------------------------------------------------------------
  // low four limit bits are tied to zero
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lower_limit <= LOWER_RESET;
      upper_limit <= UPPER_RESET;
    end
    else if (commit && index_ptr == IDX_LOWER)
    begin
      lower_limit <= word_in & LIMIT_KEEP_MASK;
    end
    else if (commit && index_ptr == IDX_UPPER)
    begin
      upper_limit <= word_in & LIMIT_KEEP_MASK;
    end
  end

  // read-only bit positions are simply never loaded
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sample_rate_select <= RATE_RESET;
      low_power_select <= 1'b0;
      latch_mode_select <= 1'b0;
      active_level_select <= 1'b0;
      fault_count_select <= FAULT_RESET;
    end
    else if (cfg_commit)
    begin
      sample_rate_select <= word_in[CFG_RATE_HI:CFG_RATE_LO];
      low_power_select <= word_in[CFG_LOW_POWER];
      latch_mode_select <= word_in[CFG_LATCH_MODE];
      active_level_select <= word_in[CFG_ACTIVE_LEVEL];
      fault_count_select <= word_in[CFG_FAULT_HI:CFG_FAULT_LO];
    end
  end

  // ------------------------------------------------------------
  // conversion scheduling
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (sample_rate_select)
      2'h0: period_cycles = TIMER_W'(PERIOD_MS_0 * CYCLES_PER_MS);
      2'h1: period_cycles = TIMER_W'(PERIOD_MS_1 * CYCLES_PER_MS);
      2'h2: period_cycles = TIMER_W'(PERIOD_MS_2 * CYCLES_PER_MS);
      2'h3: period_cycles = TIMER_W'(PERIOD_MS_3 * CYCLES_PER_MS);
    endcase
  end
  assign timer_due = (rate_timer + TIMER_W'(1)) >= period_cycles;

  // the rate timer measures start to start; held at zero in sleep
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rate_timer <= '0;
    end
    else if (low_power_select || sleep_enter || sleep_leave)
    begin
      rate_timer <= '0;
    end
    else if (conv_start)
    begin
      // the start cycle itself already counts toward the period
      rate_timer <= TIMER_W'(1);
    end
    else if (!timer_due)
    begin
      rate_timer <= rate_timer + TIMER_W'(1);
    end
  end

  // one conversion is owed straight after reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_on_pending <= 1'b1;
    end
    else if (conv_start || sleep_enter)
    begin
      power_on_pending <= 1'b0;
    end
  end

  // standby between conversions, converter powered only when measuring
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      conv_state <= st_standby;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      unique case (conv_state)
        st_standby:
        begin
          if (one_shot_req)
          begin
            conv_state <= st_convert;
            conv_start <= 1'b1;
          end
          else if ((!low_power_select || sleep_leave) && !sleep_enter
                   && (power_on_pending || timer_due || sleep_leave))
          begin
            conv_state <= st_convert;
            conv_start <= 1'b1;
          end
        end
        st_convert:
        begin
          if (conv_done)
          begin
            conv_state <= st_standby;
          end
          else if (sleep_enter && !word_in[CFG_ONE_SHOT])
          begin
            conv_state <= st_standby;
          end
        end
      endcase
    end
  end
  assign meas_power = (conv_state == st_convert);

  // one-shot bit reads one only while its own conversion runs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      one_shot_busy <= 1'b0;
    end
    else if (one_shot_req)
    begin
      one_shot_busy <= 1'b1;
    end
    else if (conv_done || conv_state == st_standby)
    begin
      one_shot_busy <= 1'b0;
    end
  end

  // result changes only on a finished conversion
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      temperature_result <= RESULT_RESET;
    end
    else if (result_valid)
    begin
      temperature_result <= conv_value;
    end
  end

  // ------------------------------------------------------------
  // alert evaluation
  // ------------------------------------------------------------
  // comparator track: count toward whichever edge is next
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmp_active <= 1'b0;
      cmp_count <= '0;
    end
    else if (result_valid)
    begin
      if ((!cmp_active && over_upper) || (cmp_active && under_lower))
      begin
        if (cmp_count + 3'd1 >= fault_target)
        begin
          cmp_active <= !cmp_active;
          cmp_count <= '0;
        end
        else
        begin
          cmp_count <= cmp_count + 3'd1;
        end
      end
      else
      begin
        cmp_count <= '0;
      end
    end
  end

  // interrupt track: alternating crossings, cleared by read or sleep;
  // a firing crossing wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_active <= 1'b0;
      int_expect_low <= 1'b0;
      int_count <= '0;
    end
    else
    begin
      if (result_valid && ((!int_expect_low && over_upper)
                           || (int_expect_low && under_lower)))
      begin
        if (int_count + 3'd1 >= fault_target)
        begin
          int_active <= 1'b1;
          int_expect_low <= !int_expect_low;
          int_count <= '0;
        end
        else
        begin
          int_count <= int_count + 3'd1;
        end
      end
      else
      begin
        if (result_valid)
        begin
          int_count <= '0;
        end
        if ((rd_req && !byte_phase) || sleep_enter)
        begin
          int_active <= 1'b0;
        end
      end
    end
  end

  // registered pin: comparator mode follows the limit flag one cycle later
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alert_pin <= 1'b1;
    end
    else if (!latch_mode_select)
    begin
      alert_pin <= active_level_select ? cmp_active
                                       : !cmp_active;
    end
    else
    begin
      alert_pin <= active_level_select ? int_active
                                       : !int_active;
    end
  end

endmodule : temp_alert_ctrl

// ===== hw/temp_alert_pkg.sv
package temp_alert_pkg;

  // ------------------------------------------------------------
  // register indices and widths
  // ------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [1:0] IDX_RESULT = 2'h0;
  localparam logic [1:0] IDX_CONFIG = 2'h1;
  localparam logic [1:0] IDX_LOWER = 2'h2;
  localparam logic [1:0] IDX_UPPER = 2'h3;

  // ------------------------------------------------------------
  // operating_configuration field positions
  // ------------------------------------------------------------
  localparam int CFG_LIMIT_FLAG = 5;
  localparam int CFG_RATE_LO = 6;
  localparam int CFG_RATE_HI = 7;
  localparam int CFG_LOW_POWER = 8;
  localparam int CFG_LATCH_MODE = 9;
  localparam int CFG_ACTIVE_LEVEL = 10;
  localparam int CFG_FAULT_LO = 11;
  localparam int CFG_FAULT_HI = 12;
  localparam int CFG_ONE_READS_ONE = 14;
  localparam int CFG_ONE_SHOT = 15;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [1:0] FAULT_RESET = 2'h0;
  localparam logic [15:0] LOWER_RESET = 16'h2580;
  localparam logic [15:0] UPPER_RESET = 16'h2800;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_KEEP_MASK = 16'hfff0;

  // ------------------------------------------------------------
  // timing: conversion periods in ms per rate code
  // ------------------------------------------------------------
  localparam int PERIOD_MS_0 = 4000;
  localparam int PERIOD_MS_1 = 1000;
  localparam int PERIOD_MS_2 = 250;
  localparam int PERIOD_MS_3 = 125;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int TIMER_W = 32;

  typedef enum logic {
    st_standby,
    st_convert
  } conv_state_e;

endpackage : temp_alert_pkg
